// *** dps_cfg.svh ***
// Constants of the dual-channel switch command layer
// Function
// - Broadcast address byte selects sole device first
// - Byte F5h after addressing starts pin reads
// - Each read byte returns a fresh pin sample
// - Byte 5Ah after addressing starts pin writes
// - Byte plus complement match: update latches, send AAh
// - Status byte after confirmation shows new state
// - Further byte pairs accepted without new command
// - Master sets latch to 1 before sensing input
// - Pin level reported separately from latch value
// - Read sampling continues until a bus reset
// - Complement mismatch: no update, FF bytes until reset
`ifndef DPS_CFG_SVH
`define DPS_CFG_SVH

// ----------------------------------------------------------------
// Command and answer bytes
// ----------------------------------------------------------------
`define DPS_SKIP_ROM    8'hcc
`define DPS_READ_CMD    8'hf5
`define DPS_WRITE_CMD   8'h5a
`define DPS_CONFIRM     8'haa
`define DPS_FILL        8'hff

// ----------------------------------------------------------------
// Status byte fields (upper nibble is the complement of the lower)
// ----------------------------------------------------------------
`define DPS_ST_PIN_A    0
`define DPS_ST_LATCH_A  1
`define DPS_ST_PIN_B    2
`define DPS_ST_LATCH_B  3

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define DPS_LATCH_RST   2'h3
`define DPS_CHANNELS    2
`define DPS_PRES_WAIT   16

`endif

// *** dps_pkg.sv ***
// Types shared by both ends of the switch command layer
package dps_pkg;

	// ----------------------------------------------------------------
	// Device sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		DPS_D_IDLE  = 4'h0,
		DPS_D_ROM   = 4'h1,
		DPS_D_FUNC  = 4'h2,
		DPS_D_READ  = 4'h3,
		DPS_D_WDATA = 4'h4,
		DPS_D_WINV  = 4'h5,
		DPS_D_WCONF = 4'h6,
		DPS_D_WSTAT = 4'h7,
		DPS_D_FILL  = 4'h8
	} dps_dev_state_t;

	// ----------------------------------------------------------------
	// Master sequencer states, steps and user operations
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		DPS_M_IDLE  = 3'h0,
		DPS_M_PWAIT = 3'h1,
		DPS_M_FETCH = 3'h2,
		DPS_M_TX    = 3'h3,
		DPS_M_RX    = 3'h4,
		DPS_M_RWAIT = 3'h5
	} dps_mst_state_t;

	typedef enum logic [1:0] {
		DPS_K_RST = 2'h0,
		DPS_K_TX  = 2'h1,
		DPS_K_RX  = 2'h2,
		DPS_K_END = 2'h3
	} dps_step_t;

	typedef enum logic [2:0] {
		DPS_OP_RESET      = 3'h0,
		DPS_OP_READ_START = 3'h1,
		DPS_OP_READ_NEXT  = 3'h2,
		DPS_OP_WRITE_START = 3'h3,
		DPS_OP_WRITE_NEXT = 3'h4
	} dps_op_t;

endpackage : dps_pkg

// *** dps_link_if.sv ***
// Slot-level link between the bus master and the switch device
`timescale 1ns/1ps
`default_nettype none

interface dps_link_if;
	logic bus_reset;
	logic presence;
	logic slot;
	logic slot_write;
	logic wbit;
	logic rbit;
	logic rbit_valid;

	modport master (
		output bus_reset,
		output slot,
		output slot_write,
		output wbit,
		input  presence,
		input  rbit,
		input  rbit_valid
	);

	modport device (
		input  bus_reset,
		input  slot,
		input  slot_write,
		input  wbit,
		output presence,
		output rbit,
		output rbit_valid
	);
endinterface : dps_link_if

`default_nettype wire

// *** dps_device.sv ***
// Switch device end: command decode, pin sampling and open-drain latches
`timescale 1ns/1ps
`default_nettype none
`include "dps_cfg.svh"

module dps_device #(
	parameter int CHANNELS = `DPS_CHANNELS
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// Link to the bus master
	dps_link_if.device      link,
	// Channel A open-drain pin
	input  wire logic       channel_a_pin_in,
	output logic            channel_a_pin_out,
	output logic            channel_a_pin_oe_n,
	// Channel B open-drain pin
	input  wire logic       channel_b_pin_in,
	output logic            channel_b_pin_out,
	output logic            channel_b_pin_oe_n
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	generate
		if (CHANNELS != 2) begin : g_bad_channels
			$error("dps_device serves exactly two channels");
		end
	endgenerate

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	dps_pkg::dps_dev_state_t state;
	dps_pkg::dps_dev_state_t next_state;
	logic [7:0]              rx;
	logic [7:0]              next_rx;
	logic [7:0]              tx;
	logic [7:0]              next_tx;
	logic [7:0]              wdata;
	logic [7:0]              next_wdata;
	logic [2:0]              cnt;
	logic [2:0]              next_cnt;
	logic [1:0]              latch;
	logic [1:0]              next_latch;
	logic                    pres;
	logic                    next_pres;
	logic                    rbit;
	logic                    next_rbit;
	logic                    rvalid;
	logic                    next_rvalid;
	logic                    drive_level;

	logic [1:0]              pin_in;
	logic [3:0]              st_low;
	logic [7:0]              sample;
	logic [7:0]              byte_in;
	logic                    rx_phase;
	logic                    tx_phase;

	// ----------------------------------------------------------------
	// Status byte: pin and latch per channel, complement above
	// ----------------------------------------------------------------
	assign pin_in = {channel_b_pin_in, channel_a_pin_in};

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_status
			// Sensed level and latch value are separate bits
			assign st_low[2*ch]     = pin_in[ch];
			assign st_low[2*ch + 1] = latch[ch];
		end
	endgenerate

	assign sample = {~st_low, st_low};

	// Serial bits arrive least significant first
	assign byte_in = {link.wbit, rx[7:1]};

	assign rx_phase = (state == dps_pkg::DPS_D_ROM) || (state == dps_pkg::DPS_D_FUNC) ||
		(state == dps_pkg::DPS_D_WDATA) || (state == dps_pkg::DPS_D_WINV);
	assign tx_phase = (state == dps_pkg::DPS_D_READ) || (state == dps_pkg::DPS_D_WCONF) ||
		(state == dps_pkg::DPS_D_WSTAT) || (state == dps_pkg::DPS_D_FILL);

	// ----------------------------------------------------------------
	// Sequencer next values
	// ----------------------------------------------------------------
	always_comb begin
		next_state  = state;
		next_rx     = rx;
		next_tx     = tx;
		next_wdata  = wdata;
		next_cnt    = cnt;
		next_latch  = latch;
		next_pres   = 1'b0;
		next_rbit   = rbit;
		next_rvalid = 1'b0;

		if (link.bus_reset) begin
			// A bus reset ends any sequence and awaits addressing
			next_state = dps_pkg::DPS_D_ROM;
			next_pres  = 1'b1;
			next_cnt   = 3'h0;
			next_tx    = `DPS_FILL;
		end else if (link.slot && link.slot_write) begin
			if (rx_phase) begin
				next_rx  = byte_in;
				next_cnt = cnt + 3'h1;
				if (cnt == 3'h7) begin
					unique case (state)
						dps_pkg::DPS_D_ROM: begin
							if (byte_in == `DPS_SKIP_ROM) begin
								next_state = dps_pkg::DPS_D_FUNC;
							end else begin
								next_state = dps_pkg::DPS_D_IDLE;
							end
						end
						dps_pkg::DPS_D_FUNC: begin
							if (byte_in == `DPS_READ_CMD) begin
								next_state = dps_pkg::DPS_D_READ;
								next_tx    = sample;
							end else if (byte_in == `DPS_WRITE_CMD) begin
								next_state = dps_pkg::DPS_D_WDATA;
							end else begin
								next_state = dps_pkg::DPS_D_IDLE;
							end
						end
						dps_pkg::DPS_D_WDATA: begin
							next_wdata = byte_in;
							next_state = dps_pkg::DPS_D_WINV;
						end
						dps_pkg::DPS_D_WINV: begin
							if (byte_in == ~wdata) begin
								// Bit 0 drives channel A, bit 1 channel B
								next_latch = wdata[1:0];
								next_tx    = `DPS_CONFIRM;
								next_state = dps_pkg::DPS_D_WCONF;
							end else begin
								next_tx    = `DPS_FILL;
								next_state = dps_pkg::DPS_D_FILL;
							end
						end
						default: begin
							next_state = state;
						end
					endcase
				end
			end
		end else if (link.slot) begin
			// Read slot: idle states answer with the released level
			next_rvalid = 1'b1;
			next_rbit   = tx[0];
			if (tx_phase) begin
				next_tx  = {1'b1, tx[7:1]};
				next_cnt = cnt + 3'h1;
				if (state == dps_pkg::DPS_D_READ && cnt == 3'h0) begin
					// Sample as the byte starts, not when the previous one ended
					next_rbit = sample[0];
					next_tx   = {1'b1, sample[7:1]};
				end
				if (cnt == 3'h7) begin
					unique case (state)
						dps_pkg::DPS_D_READ: begin
							next_tx = sample;
						end
						dps_pkg::DPS_D_WCONF: begin
							// Latches took effect one byte earlier
							next_tx    = sample;
							next_state = dps_pkg::DPS_D_WSTAT;
						end
						dps_pkg::DPS_D_WSTAT: begin
							next_tx    = `DPS_FILL;
							next_state = dps_pkg::DPS_D_WDATA;
						end
						dps_pkg::DPS_D_FILL: begin
							next_tx = `DPS_FILL;
						end
						default: begin
							next_tx = tx;
						end
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequencer registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state  <= dps_pkg::DPS_D_IDLE;
			rx     <= 8'h00;
			tx     <= `DPS_FILL;
			wdata  <= 8'h00;
			cnt    <= 3'h0;
			latch  <= `DPS_LATCH_RST;
			pres   <= 1'b0;
			rbit   <= 1'b1;
			rvalid <= 1'b0;
		end else begin
			state  <= next_state;
			rx     <= next_rx;
			tx     <= next_tx;
			wdata  <= next_wdata;
			cnt    <= next_cnt;
			latch  <= next_latch;
			pres   <= next_pres;
			rbit   <= next_rbit;
			rvalid <= next_rvalid;
		end
	end

	// ----------------------------------------------------------------
	// Open-drain drive: pull low while the latch holds 0
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		drive_level <= 1'b0;
	end

	assign channel_a_pin_out  = drive_level;
	assign channel_b_pin_out  = drive_level;
	assign channel_a_pin_oe_n = latch[0];
	assign channel_b_pin_oe_n = latch[1];

	// ----------------------------------------------------------------
	// Link answers
	// ----------------------------------------------------------------
	assign link.presence   = pres;
	assign link.rbit       = rbit;
	assign link.rbit_valid = rvalid;

endmodule : dps_device

`default_nettype wire

// *** dps_master.sv ***
// Bus master end: runs reset, addressing, read and write sequences
`timescale 1ns/1ps
`default_nettype none
`include "dps_cfg.svh"

module dps_master #(
	parameter int PRES_WAIT = `DPS_PRES_WAIT
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// Link to the device
	dps_link_if.master            link,
	// User request
	input  wire logic             req_valid,
	input  wire dps_pkg::dps_op_t req_op,
	input  wire logic [7:0]       req_data,
	output logic                  req_ready,
	// User answer
	output logic                  done,
	output logic [7:0]            rsp_byte,
	output logic                  rsp_ok
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	generate
		if (PRES_WAIT < 1 || PRES_WAIT > 255) begin : g_bad_wait
			$error("dps_master PRES_WAIT must be 1 to 255");
		end
	endgenerate

	localparam logic [7:0] WAIT_MAX = 8'(PRES_WAIT);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	dps_pkg::dps_mst_state_t state, next_state;
	dps_pkg::dps_op_t        op, next_op;
	logic [2:0]              idx, next_idx;
	logic [7:0]              data, next_data;
	logic [7:0]              sh, next_sh;
	logic [2:0]              cnt, next_cnt;
	logic [7:0]              wcnt, next_wcnt;
	logic                    ok, next_ok;
	logic [7:0]              rsp, next_rsp;
	logic                    dn, next_dn;
	logic                    rst_o, next_rst_o;
	logic                    slot_o, next_slot_o;
	logic                    sw_o, next_sw_o;
	logic                    wb_o, next_wb_o;
	logic [9:0]              step;

	// Step list per operation: kind and byte
	function automatic logic [9:0] step_of(input dps_pkg::dps_op_t o, input logic [2:0] i,
		input logic [7:0] d);
		logic wr;
		wr = (o == dps_pkg::DPS_OP_WRITE_START) || (o == dps_pkg::DPS_OP_WRITE_NEXT);
		step_of = {dps_pkg::DPS_K_END, 8'h00};
		unique case (i)
			3'h0: step_of = (o == dps_pkg::DPS_OP_RESET || o == dps_pkg::DPS_OP_READ_START ||
				o == dps_pkg::DPS_OP_WRITE_START) ? {dps_pkg::DPS_K_RST, 8'h00} : step_of;
			3'h1: step_of = (o == dps_pkg::DPS_OP_RESET) ? step_of :
				{dps_pkg::DPS_K_TX, `DPS_SKIP_ROM};
			3'h2: step_of = {dps_pkg::DPS_K_TX, wr ? `DPS_WRITE_CMD : `DPS_READ_CMD};
			// Input channels need their latch bit at 1 in d
			3'h3: step_of = wr ? {dps_pkg::DPS_K_TX, d} : {dps_pkg::DPS_K_RX, 8'h00};
			3'h4: step_of = wr ? {dps_pkg::DPS_K_TX, ~d} : step_of;
			3'h5: step_of = {dps_pkg::DPS_K_RX, 8'h00};
			3'h6: step_of = {dps_pkg::DPS_K_RX, 8'h00};
			3'h7: step_of = {dps_pkg::DPS_K_END, 8'h00};
		endcase
	endfunction : step_of

	assign step = step_of(op, idx, data);

	// ----------------------------------------------------------------
	// Sequencer next values
	// ----------------------------------------------------------------
	always_comb begin
		next_state  = state;
		next_op     = op;
		next_idx    = idx;
		next_data   = data;
		next_sh     = sh;
		next_cnt    = cnt;
		next_wcnt   = wcnt;
		next_ok     = ok;
		next_rsp    = rsp;
		next_dn     = 1'b0;
		next_rst_o  = 1'b0;
		next_slot_o = 1'b0;
		next_sw_o   = sw_o;
		next_wb_o   = wb_o;
		unique case (state)
			dps_pkg::DPS_M_IDLE: begin
				if (req_valid) begin
					next_op    = req_op;
					next_data  = req_data;
					next_ok    = 1'b1;
					// Continued reads and writes skip reset and command
					next_idx   = (req_op == dps_pkg::DPS_OP_READ_NEXT ||
						req_op == dps_pkg::DPS_OP_WRITE_NEXT) ? 3'h3 : 3'h0;
					next_state = dps_pkg::DPS_M_FETCH;
				end
			end
			dps_pkg::DPS_M_FETCH: begin
				next_idx = idx + 3'h1;
				next_cnt = 3'h0;
				next_sh  = step[7:0];
				unique case (dps_pkg::dps_step_t'(step[9:8]))
					dps_pkg::DPS_K_RST: begin
						next_rst_o = 1'b1;
						next_wcnt  = 8'h00;
						next_state = dps_pkg::DPS_M_PWAIT;
					end
					dps_pkg::DPS_K_TX:  next_state = dps_pkg::DPS_M_TX;
					dps_pkg::DPS_K_RX:  next_state = dps_pkg::DPS_M_RX;
					dps_pkg::DPS_K_END: begin
						next_dn    = 1'b1;
						next_state = dps_pkg::DPS_M_IDLE;
					end
				endcase
			end
			dps_pkg::DPS_M_PWAIT: begin
				next_wcnt = wcnt + 8'h01;
				if (link.presence) begin
					next_state = dps_pkg::DPS_M_FETCH;
				end else if (wcnt == WAIT_MAX) begin
					next_ok    = 1'b0;
					next_dn    = 1'b1;
					next_state = dps_pkg::DPS_M_IDLE;
				end
			end
			dps_pkg::DPS_M_TX: begin
				// One write slot per cycle, least significant bit first
				next_slot_o = 1'b1;
				next_sw_o   = 1'b1;
				next_wb_o   = sh[0];
				next_sh     = {1'b0, sh[7:1]};
				next_cnt    = cnt + 3'h1;
				if (cnt == 3'h7) begin
					next_state = dps_pkg::DPS_M_FETCH;
				end
			end
			dps_pkg::DPS_M_RX: begin
				next_slot_o = 1'b1;
				next_sw_o   = 1'b0;
				next_state  = dps_pkg::DPS_M_RWAIT;
			end
			dps_pkg::DPS_M_RWAIT: begin
				if (link.rbit_valid) begin
					next_sh  = {link.rbit, sh[7:1]};
					next_cnt = cnt + 3'h1;
					if (cnt == 3'h7) begin
						next_rsp = {link.rbit, sh[7:1]};
						if (idx == 3'h6 && {link.rbit, sh[7:1]} != `DPS_CONFIRM) begin
							next_ok = 1'b0;
						end
						next_state = dps_pkg::DPS_M_FETCH;
					end else begin
						next_state = dps_pkg::DPS_M_RX;
					end
				end
			end
			default: next_state = dps_pkg::DPS_M_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state  <= dps_pkg::DPS_M_IDLE;
			op     <= dps_pkg::DPS_OP_RESET;
			idx    <= 3'h0;
			data   <= 8'h00;
			sh     <= 8'h00;
			cnt    <= 3'h0;
			wcnt   <= 8'h00;
			ok     <= 1'b0;
			rsp    <= 8'h00;
			dn     <= 1'b0;
			rst_o  <= 1'b0;
			slot_o <= 1'b0;
			sw_o   <= 1'b0;
			wb_o   <= 1'b1;
			req_ready <= 1'b0;
		end else begin
			state  <= next_state;
			op     <= next_op;
			idx    <= next_idx;
			data   <= next_data;
			sh     <= next_sh;
			cnt    <= next_cnt;
			wcnt   <= next_wcnt;
			ok     <= next_ok;
			rsp    <= next_rsp;
			dn     <= next_dn;
			rst_o  <= next_rst_o;
			slot_o <= next_slot_o;
			sw_o   <= next_sw_o;
			wb_o   <= next_wb_o;
			req_ready <= (next_state == dps_pkg::DPS_M_IDLE);
		end
	end

	assign done            = dn;
	assign rsp_byte        = rsp;
	assign rsp_ok          = ok;
	assign link.bus_reset  = rst_o;
	assign link.slot       = slot_o;
	assign link.slot_write = sw_o;
	assign link.wbit       = wb_o;

endmodule : dps_master

`default_nettype wire

// *** dps_link_sva.sv ***
// Link-level checks between the bus master and the switch device
`timescale 1ns/1ps
`default_nettype none
`include "dps_cfg.svh"

module dps_link_sva (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Link signals
	input wire logic bus_reset,
	input wire logic presence,
	input wire logic slot,
	input wire logic slot_write,
	input wire logic wbit,
	input wire logic rbit,
	input wire logic rbit_valid
);
	localparam logic [7:0] ADDR = `DPS_SKIP_ROM;

	logic [3:0] wcount;
	logic [3:0] next_wcount;

	// ----------------------------------------------------------------
	// Write bits counted since the last bus reset, stopping at eight
	// ----------------------------------------------------------------
	always_comb begin
		next_wcount = wcount;
		if (bus_reset) begin
			next_wcount = 4'h0;
		end else if (slot && slot_write && wcount < 4'h8) begin
			next_wcount = wcount + 4'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wcount <= 4'h8;
		end else begin
			wcount <= next_wcount;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_read_slot;
		slot && !slot_write && !bus_reset;
	endsequence

	sequence s_reply;
		rbit_valid;
	endsequence

	a_presence_answer: assert property (bus_reset |=> presence)
		else $error("presence missing after bus reset");
	a_presence_cause: assert property (presence |-> $past(bus_reset))
		else $error("presence without bus reset");
	a_reset_single: assert property (bus_reset |=> !bus_reset)
		else $error("bus reset longer than one cycle");
	a_quiet_after_reset: assert property (bus_reset |=> !slot [*1])
		else $error("slot during presence");
	a_read_answer: assert property (s_read_slot |=> s_reply)
		else $error("read slot not answered");
	a_reply_cause: assert property (rbit_valid |-> $past(slot && !slot_write))
		else $error("answer without read slot");
	a_rbit_hold: assert property ($changed(rbit) |-> rbit_valid)
		else $error("read bit changed outside an answer");
	a_address_lsb: assert property (slot && slot_write && wcount < 4'h8 |-> wbit == ADDR[wcount[2:0]])
		else $error("address byte bit wrong");
endmodule : dps_link_sva

`default_nettype wire

// *** test_dual_pio_switch_command_layer.sv ***
// Self-checking bench joining master and device ends of the link
`timescale 1ns/1ps
`default_nettype none

module test_dual_pio_switch_command_layer;
	logic              clock = 1'b0;
	logic              rst_n = 1'b0;
	logic              req_valid = 1'b0;
	dps_pkg::dps_op_t  req_op = dps_pkg::DPS_OP_RESET;
	logic [7:0]        req_data = 8'h00;
	logic              req_ready;
	logic              done;
	logic              rsp_ok;
	logic [7:0]        rsp_byte;
	logic              ext_a = 1'b1;
	logic              ext_b = 1'b1;
	logic              a_out, a_oe_n, b_out, b_oe_n;
	logic              a2_out, a2_oe_n, b2_out, b2_oe_n;
	logic [7:0]        wsr = 8'h00;
	logic [7:0]        wq[$];
	logic [7:0]        exp_w[6] = '{8'hcc, 8'h5a, 8'hfc, 8'h03, 8'hfd, 8'h02};
	logic [7:0]        got;
	int                wbits = 0;
	int                n_fail = 0;
	int                comparisons = 0;
	int                cycles = 0;

	dps_link_if link ();
	dps_link_if link2 ();

	always #12.5 clock = ~clock;

	// ----------------------------------------------------------------
	// Design ends and checker
	// ----------------------------------------------------------------
	dps_master #(.PRES_WAIT(4)) dps_master_inst (.clock(clock), .rst_n(rst_n), .link(link),
		.req_valid(req_valid), .req_op(req_op), .req_data(req_data), .req_ready(req_ready),
		.done(done), .rsp_byte(rsp_byte), .rsp_ok(rsp_ok));
	dps_device dps_device_inst (.clock(clock), .rst_n(rst_n), .link(link),
		.channel_a_pin_in(a_oe_n ? ext_a : a_out), .channel_a_pin_out(a_out),
		.channel_a_pin_oe_n(a_oe_n), .channel_b_pin_in(b_oe_n ? ext_b : b_out),
		.channel_b_pin_out(b_out), .channel_b_pin_oe_n(b_oe_n));
	// Second device driven directly by the bench, to break the master's rules
	dps_device dps_device_inst_b (.clock(clock), .rst_n(rst_n), .link(link2),
		.channel_a_pin_in(a2_oe_n ? 1'b1 : a2_out), .channel_a_pin_out(a2_out),
		.channel_a_pin_oe_n(a2_oe_n), .channel_b_pin_in(b2_oe_n ? 1'b1 : b2_out),
		.channel_b_pin_out(b2_out), .channel_b_pin_oe_n(b2_oe_n));
	dps_link_sva dps_link_sva_inst (.clock(clock), .rst_n(rst_n), .bus_reset(link.bus_reset),
		.presence(link.presence), .slot(link.slot), .slot_write(link.slot_write),
		.wbit(link.wbit), .rbit(link.rbit), .rbit_valid(link.rbit_valid));

	// ----------------------------------------------------------------
	// Wire monitor and timeout
	// ----------------------------------------------------------------
	always @(posedge clock) begin
		cycles++;
		if (link.bus_reset) begin
			wbits = 0;
		end else if (link.slot && link.slot_write) begin
			wsr = {link.wbit, wsr[7:1]};
			wbits++;
			if (wbits % 8 == 0) begin
				wq.push_back(wsr);
			end
		end
		if (cycles == 8000) begin
			n_fail++;
			give_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task check_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check_byte

	task check_bit(input string what, input logic exp, input logic seen);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %b seen %b", what, exp, seen);
		end
	endtask : check_bit

	task do_op(input dps_pkg::dps_op_t op, input logic [7:0] d);
		int n;
		@(negedge clock);
		req_valid = 1'b1;
		req_op = op;
		req_data = d;
		n = 0;
		// Ready seen high here means the next rising edge takes the request
		while (req_ready !== 1'b1 && n < 100) begin
			@(negedge clock);
			n++;
		end
		@(negedge clock);
		req_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 200) begin
			@(negedge clock);
			n++;
		end
		check_bit("done", 1'b1, done);
	endtask : do_op

	task slot2(input logic w, input logic b, output logic r);
		int n;
		@(negedge clock);
		link2.slot = 1'b1;
		link2.slot_write = w;
		link2.wbit = b;
		@(negedge clock);
		link2.slot = 1'b0;
		link2.wbit = ~b;
		n = 0;
		while (!w && link2.rbit_valid !== 1'b1 && n < 4) begin
			@(negedge clock);
			n++;
		end
		r = link2.rbit;
	endtask : slot2

	task tx2(input logic [7:0] v);
		logic r;
		for (int i = 0; i < 8; i++) begin
			slot2(1'b1, v[i], r);
		end
	endtask : tx2

	task rx2(output logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			slot2(1'b0, 1'b1, v[i]);
		end
	endtask : rx2

	task reset2;
		@(negedge clock);
		link2.bus_reset = 1'b1;
		@(negedge clock);
		link2.bus_reset = 1'b0;
		check_bit("second presence", 1'b1, link2.presence);
	endtask : reset2

	task give_verdict;
		if (n_fail == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		link2.bus_reset = 1'b0;
		link2.slot = 1'b0;
		link2.slot_write = 1'b0;
		link2.wbit = 1'b1;
		repeat (16) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		// Repeated sampling with released pins, then pins pulled low outside
		do_op(dps_pkg::DPS_OP_RESET, 8'h00);
		check_bit("reset presence", 1'b1, rsp_ok);
		do_op(dps_pkg::DPS_OP_READ_START, 8'h00);
		check_byte("sample 1", 8'h0f, rsp_byte);
		ext_a = 1'b0;
		do_op(dps_pkg::DPS_OP_READ_NEXT, 8'h00);
		check_byte("sample 2", 8'h1e, rsp_byte);
		ext_a = 1'b1;
		ext_b = 1'b0;
		do_op(dps_pkg::DPS_OP_READ_NEXT, 8'h00);
		check_byte("sample 3", 8'h4b, rsp_byte);
		ext_b = 1'b1;
		// Two writes in one command
		wq.delete();
		do_op(dps_pkg::DPS_OP_RESET, 8'h00);
		do_op(dps_pkg::DPS_OP_WRITE_START, 8'hfc);
		check_byte("status 1", 8'hf0, rsp_byte);
		check_bit("confirm 1", 1'b1, rsp_ok);
		check_bit("latch a low", 1'b0, a_oe_n);
		check_bit("latch b low", 1'b0, b_oe_n);
		check_bit("drive a level", 1'b0, a_out);
		check_bit("drive b level", 1'b0, b_out);
		do_op(dps_pkg::DPS_OP_WRITE_NEXT, 8'hfd);
		check_byte("status 2", 8'hc3, rsp_byte);
		check_bit("confirm 2", 1'b1, rsp_ok);
		check_bit("latch a high", 1'b1, a_oe_n);
		check_bit("latch b kept low", 1'b0, b_oe_n);
		check_byte("wire byte count", 8'h06, 8'(wq.size()));
		for (int i = 0; i < wq.size() && i < 6; i++) begin
			check_byte("wire byte", exp_w[i], wq[i]);
		end
		// Bad complement, unknown command and a direct sample on the second device
		reset2();
		tx2(8'hcc);
		tx2(8'h5a);
		tx2(8'h55);
		tx2(8'h55);
		rx2(got);
		check_byte("fill 1", 8'hff, got);
		rx2(got);
		check_byte("fill 2", 8'hff, got);
		check_bit("latch b unchanged", 1'b1, b2_oe_n);
		reset2();
		tx2(8'hcc);
		tx2(8'h33);
		rx2(got);
		check_byte("unknown command", 8'hff, got);
		reset2();
		tx2(8'hcc);
		tx2(8'hf5);
		rx2(got);
		check_byte("direct sample", 8'h0f, got);
		give_verdict();
	end
endmodule : test_dual_pio_switch_command_layer

`default_nettype wire
